// File: src/shrb_bank.sv
// Three-wire serial load register, four hold registers and operation-mode decode
`timescale 1ns/1ps
`include "shrb_consts.svh"

// Operation
// - With strobe low, each serial clock rise shifts one bit in, MSB first.
// - Strobe falling edge copies load register into the addressed hold register.
// - Non-frequency word writes never disturb the frequency words or update pulse.
// - Load bits 1:0 pick operation, calibration, frequency one or frequency two.
// - Bits 4:2 set pump current, 200 uA per step from 200 to 1600.
// - Bits 6:5 set pump delay 2, 4, 7 or 9 ns.
// - Bit 7 sets detector polarity, 0 negative, 1 positive.
// - Bit 8 set floats and disables the charge pump.
// - Bits 12:10 form one supply code: 0XX 0 V, 10X 1.8 V, 11X 2.4 V.
// - Bits 14:13 set reference bandwidth 20, 30, 40 or 50 MHz.
// - Bits 17:15 route lock detect, reference, feedback or loop test to pin.
module shrb_bank
   import shrb_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    sclk_i,
   input  wire logic                    sdata_i,
   input  wire logic                    latch_strobe_i,
   input  wire logic                    lock_detect_i,
   input  wire logic                    ref_div_out_i,
   input  wire logic                    fb_div_out_i,
   input  wire logic                    loop_test_i,
   output logic [`SHRB_WORD_W-1:0]      operation_mode_word_o,
   output logic [`SHRB_WORD_W-1:0]      auto_calibration_word_o,
   output logic [`SHRB_WORD_W-1:0]      frequency_word_one_o,
   output logic [`SHRB_WORD_W-1:0]      frequency_word_two_o,
   output logic                         freq_update_o,
   output logic [10:0]                  pump_current_ua_o,
   output logic [3:0]                   pump_delay_ns_o,
   output logic                         detector_polarity_o,
   output logic                         pump_float_select_o,
   output logic [11:0]                  supply_mv_o,
   output logic [5:0]                   reference_bandwidth_mhz_o,
   output logic                         lock_indicator_pin_o
);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [2:0]                sclk_ff;
   logic [2:0]                strobe_ff;
   logic [1:0]                sdata_ff;
   logic [`SHRB_WORD_W-1:0]   load_ff;
   logic [`SHRB_WORD_W-1:0]   opmode_ff;
   logic [`SHRB_WORD_W-1:0]   calib_ff;
   logic [`SHRB_WORD_W-1:0]   freq1_ff;
   logic [`SHRB_WORD_W-1:0]   freq2_ff;
   logic                      fupd_ff;
   logic [10:0]               cur_ff;
   logic [3:0]                dly_ff;
   logic                      pol_ff;
   logic                      float_ff;
   logic [11:0]               sup_ff;
   logic [5:0]                bw_ff;
   logic                      pin_ff;

   // Pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_ff   <= 3'h0;
         strobe_ff <= 3'h7;
         sdata_ff  <= 2'h0;
      end else begin
         sclk_ff   <= {sclk_ff[1:0], sclk_i};
         strobe_ff <= {strobe_ff[1:0], latch_strobe_i};
         sdata_ff  <= {sdata_ff[0], sdata_i};
      end
   end

   // Edge detection on synchronised pins
   wire        sclk_rise   = sclk_ff[1] & ~sclk_ff[2];
   wire        strobe_low  = ~strobe_ff[1];
   wire        strobe_fall = strobe_ff[2] & ~strobe_ff[1];
   wire        shift_en    = sclk_rise & strobe_low;
   wire        data_bit    = sdata_ff[1];

   // Address decode of the word in the load register
   wire shrb_word_t word_sel = shrb_word_t'(load_ff[`SHRB_ADDR_MSB:0]);
   wire        wr_opmode  = strobe_fall & (word_sel == SHRB_W_OPMODE);
   wire        wr_calib   = strobe_fall & (word_sel == SHRB_W_CALIB);
   wire        wr_freq1   = strobe_fall & (word_sel == SHRB_W_FREQ1);
   wire        wr_freq2   = strobe_fall & (word_sel == SHRB_W_FREQ2);

   // Load shift register, gated by strobe low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_ff <= `SHRB_WORD_RST;
      end else if (shift_en) begin
         load_ff <= {load_ff[`SHRB_WORD_W-2:0], data_bit};
      end
   end

   // Hold registers, each written only by its own address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opmode_ff <= `SHRB_OPMODE_RST;
         calib_ff  <= `SHRB_WORD_RST;
         freq1_ff  <= `SHRB_WORD_RST;
         freq2_ff  <= `SHRB_WORD_RST;
         fupd_ff   <= 1'b0;
      end else begin
         if (wr_opmode) opmode_ff <= load_ff;
         if (wr_calib)  calib_ff  <= load_ff;
         if (wr_freq1)  freq1_ff  <= load_ff;
         if (wr_freq2)  freq2_ff  <= load_ff;
         fupd_ff <= wr_freq1 | wr_freq2;
      end
   end

   // Operation-mode field extraction
   wire [2:0]  cur_code = opmode_ff[`SHRB_CUR_MSB:`SHRB_CUR_LSB];
   wire [1:0]  dly_code = opmode_ff[`SHRB_DLY_MSB:`SHRB_DLY_LSB];
   wire [1:0]  bw_code  = opmode_ff[`SHRB_BW_MSB:`SHRB_BW_LSB];
   wire [2:0]  mux_code = opmode_ff[`SHRB_MUX_MSB:`SHRB_MUX_LSB];
   wire [10:0] nxt_cur  = 11'(({8'h00, cur_code} + 11'h001) * `SHRB_CUR_STEP_UA);
   wire [3:0]  nxt_dly  = (dly_code == 2'h0) ? `SHRB_DLY_00_NS :
                          (dly_code == 2'h1) ? `SHRB_DLY_01_NS :
                          (dly_code == 2'h2) ? `SHRB_DLY_10_NS : `SHRB_DLY_11_NS;
   wire [11:0] nxt_sup  = !opmode_ff[`SHRB_PLL_SUP_BIT] ? `SHRB_SUP_OFF_MV :
                          !opmode_ff[`SHRB_DIV_SUP_BIT] ? `SHRB_SUP_LOW_MV : `SHRB_SUP_HIGH_MV;
   wire [5:0]  nxt_bw   = 6'(`SHRB_BW_BASE_MHZ + 6'({4'h0, bw_code} * `SHRB_BW_STEP_MHZ));
   wire        nxt_pin  = (mux_code == `SHRB_MUX_LOCK)   ? lock_detect_i :
                          (mux_code == `SHRB_MUX_REFDIV) ? ref_div_out_i :
                          (mux_code == `SHRB_MUX_FBDIV)  ? fb_div_out_i  :
                          (mux_code == `SHRB_MUX_TEST)   ? loop_test_i   : 1'b0;

   // Registered decode outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff   <= `SHRB_CUR_STEP_UA;
         dly_ff   <= `SHRB_DLY_00_NS;
         pol_ff   <= 1'b0;
         float_ff <= 1'b0;
         sup_ff   <= `SHRB_SUP_LOW_MV;
         bw_ff    <= `SHRB_BW_BASE_MHZ;
         pin_ff   <= 1'b0;
      end else begin
         cur_ff   <= nxt_cur;
         dly_ff   <= nxt_dly;
         pol_ff   <= opmode_ff[`SHRB_POL_BIT];
         float_ff <= opmode_ff[`SHRB_FLOAT_BIT];
         sup_ff   <= nxt_sup;
         bw_ff    <= nxt_bw;
         pin_ff   <= nxt_pin;
      end
   end

   // Output drive
   assign operation_mode_word_o     = opmode_ff;
   assign auto_calibration_word_o   = calib_ff;
   assign frequency_word_one_o      = freq1_ff;
   assign frequency_word_two_o      = freq2_ff;
   assign freq_update_o             = fupd_ff;
   assign pump_current_ua_o         = cur_ff;
   assign pump_delay_ns_o           = dly_ff;
   assign detector_polarity_o       = pol_ff;
   assign pump_float_select_o       = float_ff;
   assign supply_mv_o               = sup_ff;
   assign reference_bandwidth_mhz_o = bw_ff;
   assign lock_indicator_pin_o      = pin_ff;

   // Serial shift checks
   sequence s_shift_edge;
      sclk_rise && strobe_low;
   endsequence
   sequence s_latch_op;
      strobe_fall && load_ff[1:0] == 2'h0;
   endsequence

   a_shift_msb_first: assert property (
      s_shift_edge |=> load_ff == {$past(load_ff[`SHRB_WORD_W-2:0]), $past(data_bit)})
      else $error("load register did not shift in the sampled bit");
   a_shift_gated_off: assert property (
      !(sclk_rise && strobe_low) |=> $stable(load_ff))
      else $error("load register changed without a gated clock edge");

   // Latch and hold checks
   a_latch_opmode: assert property (
      s_latch_op ##1 1'b1 |-> opmode_ff == $past(load_ff) ##1
         cur_ff == 11'(({8'h00, $past(load_ff[`SHRB_CUR_MSB:`SHRB_CUR_LSB], 2)} + 11'h001) * 11'h0C8))
      else $error("operation word not latched from load register");
   a_addr_decode: assert property (
      strobe_fall |=> ($past(load_ff[1:0]) == 2'h3) ? freq2_ff == $past(load_ff) :
                      ($past(load_ff[1:0]) == 2'h2) ? freq1_ff == $past(load_ff) :
                      ($past(load_ff[1:0]) == 2'h1) ? calib_ff == $past(load_ff) : opmode_ff == $past(load_ff))
      else $error("hold register address decode wrong");
   a_hold_keeps: assert property (
      !strobe_fall |=> $stable(opmode_ff) && $stable(calib_ff) && $stable(freq1_ff) && $stable(freq2_ff))
      else $error("hold register changed without a latch");
   a_freq_quiet: assert property (
      strobe_fall && !load_ff[1] |=> $stable(freq1_ff) && $stable(freq2_ff) && !freq_update_o)
      else $error("non-frequency word disturbed frequency state");

   // Decode checks
   a_pump_current: assert property (
      1'b1 |=> cur_ff == 11'(({8'h00, $past(cur_code)} + 11'h001) * 11'h0C8))
      else $error("pump current decode wrong");
   a_pump_delay: assert property (
      1'b1 |=> dly_ff == (($past(dly_code) == 2'h0) ? 4'h2 : ($past(dly_code) == 2'h1) ? 4'h4 :
                          ($past(dly_code) == 2'h2) ? 4'h7 : 4'h9))
      else $error("pump delay decode wrong");
   a_pol_float: assert property (
      1'b1 |=> pol_ff == $past(opmode_ff[7]) && float_ff == $past(opmode_ff[8]))
      else $error("polarity or float select wrong");
   a_supply_code: assert property (
      1'b1 |=> sup_ff == (!$past(opmode_ff[12]) ? 12'h000 : ($past(opmode_ff[11]) ? 12'h960 : 12'h708)))
      else $error("supply code decode wrong");
   a_bandwidth: assert property (
      1'b1 |=> bw_ff == 6'(6'h14 + 6'({4'h0, $past(bw_code)} * 6'h0A)))
      else $error("bandwidth decode wrong");
   a_lock_mux: assert property (
      1'b1 |=> pin_ff == (($past(mux_code) == 3'h0) ? $past(lock_detect_i) :
                          ($past(mux_code) == 3'h1) ? $past(ref_div_out_i) :
                          ($past(mux_code) == 3'h2) ? $past(fb_div_out_i)  :
                          ($past(mux_code) == 3'h7) ? $past(loop_test_i)   : 1'b0))
      else $error("lock indicator pin routed from wrong source");

endmodule

// File: include/shrb_consts.svh
// Constants for the serial hold register bank: widths, fields, reset values, scales
`ifndef SHRB_CONSTS_SVH
`define SHRB_CONSTS_SVH
`define SHRB_WORD_W        26
`define SHRB_ADDR_MSB      1
`define SHRB_CUR_MSB       4
`define SHRB_CUR_LSB       2
`define SHRB_DLY_MSB       6
`define SHRB_DLY_LSB       5
`define SHRB_POL_BIT       7
`define SHRB_FLOAT_BIT     8
`define SHRB_MOD_SUP_BIT   10
`define SHRB_DIV_SUP_BIT   11
`define SHRB_PLL_SUP_BIT   12
`define SHRB_BW_MSB        14
`define SHRB_BW_LSB        13
`define SHRB_MUX_MSB       17
`define SHRB_MUX_LSB       15
`define SHRB_OPMODE_RST    26'h0001000
`define SHRB_WORD_RST      26'h0000000
`define SHRB_CUR_STEP_UA   11'h0C8
`define SHRB_DLY_00_NS     4'h2
`define SHRB_DLY_01_NS     4'h4
`define SHRB_DLY_10_NS     4'h7
`define SHRB_DLY_11_NS     4'h9
`define SHRB_SUP_OFF_MV    12'h000
`define SHRB_SUP_LOW_MV    12'h708
`define SHRB_SUP_HIGH_MV   12'h960
`define SHRB_BW_BASE_MHZ   6'h14
`define SHRB_BW_STEP_MHZ   6'h0A
`define SHRB_MUX_LOCK      3'h0
`define SHRB_MUX_REFDIV    3'h1
`define SHRB_MUX_FBDIV     3'h2
`define SHRB_MUX_TEST      3'h7
`endif

// File: include/shrb_pkg.sv
// Types for the serial hold register bank
package shrb_pkg;
   typedef enum logic [1:0] {
      SHRB_W_OPMODE = 2'b00,
      SHRB_W_CALIB  = 2'b01,
      SHRB_W_FREQ1  = 2'b10,
      SHRB_W_FREQ2  = 2'b11
   } shrb_word_t;
endpackage

// File: tb/shrb_ctrl_model.sv
// Serial controller model driving the three-wire programming pins
`timescale 1ns/1ps
module shrb_ctrl_model (
   output logic   sclk_o,
   output logic   sdata_o,
   output logic   latch_strobe_o
);
   // Idle pins: serial clock still, strobe high
   initial begin
      sclk_o         = 1'b0;
      sdata_o        = 1'b0;
      latch_strobe_o = 1'b1;
   end
   // One 26-bit word MSB first, then a strobe pulse whose fall latches it
   task automatic send_word(input logic [25:0] w);
      #1; // Step off the sampling edge of the bench clock
      latch_strobe_o = 1'b0;
      #40;
      for (int b = 25; b >= 0; b--) begin
         sdata_o = w[b];
         #40 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
      end
      #20 sdata_o = ~w[0]; // Hold time over, line no longer shows the bit
      #20 latch_strobe_o = 1'b1;
      #40 latch_strobe_o = 1'b0;
      #40;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the serial hold register bank
`timescale 1ns/1ps
`include "shrb_consts.svh"
module testbench;
   import shrb_pkg::*;
   logic         clk_i, rst_i, sclk, sdata, strobe, lck, rdv, fbd, tst, upd, pol, flt, pin;
   logic [25:0]  w0, w1, w2, w3, w, exp_w [4];
   logic [10:0]  cur;
   logic [3:0]   dly;
   logic [11:0]  sup;
   logic [5:0]   bw;
   logic [2:0]   mux_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h4, 3'h5, 3'h6};
   int           num_errors, samples_checked, pulses, exp_pulses;
   shrb_ctrl_model shrb_ctrl_model_inst (.sclk_o(sclk), .sdata_o(sdata), .latch_strobe_o(strobe));
   shrb_bank shrb_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sdata_i(sdata),
      .latch_strobe_i(strobe), .lock_detect_i(lck), .ref_div_out_i(rdv), .fb_div_out_i(fbd),
      .loop_test_i(tst), .operation_mode_word_o(w0), .auto_calibration_word_o(w1),
      .frequency_word_one_o(w2), .frequency_word_two_o(w3), .freq_update_o(upd),
      .pump_current_ua_o(cur), .pump_delay_ns_o(dly), .detector_polarity_o(pol),
      .pump_float_select_o(flt), .supply_mv_o(sup), .reference_bandwidth_mhz_o(bw),
      .lock_indicator_pin_o(pin));
   // Clock generation
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Count update pulses, one per cycle high
   always @(posedge clk_i) if (upd === 1'b1) pulses++;
   // Comparison of any result
   task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Expected decodes of an operation-mode word
   function automatic logic [3:0] f_dly(input logic [1:0] c);
      return c == 2'h0 ? `SHRB_DLY_00_NS : c == 2'h1 ? `SHRB_DLY_01_NS : c == 2'h2 ? `SHRB_DLY_10_NS : `SHRB_DLY_11_NS;
   endfunction
   function automatic logic [11:0] f_sup(input logic [2:0] c);
      return !c[2] ? 12'h000 : c[1] ? 12'h960 : 12'h708;
   endfunction
   function automatic logic f_pin(input logic [2:0] m);
      return m == 3'h0 ? lck : m == 3'h1 ? rdv : m == 3'h2 ? fbd : m == 3'h7 ? tst : 1'b0;
   endfunction
   // Compare all four hold registers and the decodes except the lock pin
   task automatic chk_all();
      chk(w0, exp_w[0], "opmode");
      chk(w1, exp_w[1], "calib");
      chk(w2, exp_w[2], "freq1");
      chk(w3, exp_w[3], "freq2");
      chk(26'(cur), 26'((exp_w[0][4:2] + 11'h001) * 11'h0C8), "current");
      chk(26'(dly), 26'(f_dly(exp_w[0][6:5])), "delay");
      chk(26'(pol), 26'(exp_w[0][7]), "polarity");
      chk(26'(flt), 26'(exp_w[0][8]), "float");
      chk(26'(sup), 26'(f_sup(exp_w[0][12:10])), "supply");
      chk(26'(bw), 26'(6'h14 + 6'h0A * exp_w[0][14:13]), "bandwidth");
      chk(26'(pulses), 26'(exp_pulses), "update pulses");
   endtask
   // Watchdog
   initial begin
      repeat (100000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      {rst_i, lck, rdv, fbd, tst} = 5'h10;
      {num_errors, samples_checked, pulses, exp_pulses} = '0;
      exp_w = '{26'h0001000, 26'h0000000, 26'h0000000, 26'h0000000};
      void'($urandom(90));
      repeat (10) @(posedge clk_i);
      #1 rst_i = 1'b0;
      repeat (5) @(posedge clk_i);
      chk_all();
      // Each address in turn, opmode words sweep every multi-bit field code, polarity and float left random
      for (int i = 0; i < 32; i++) begin
         w = 26'($urandom);
         w[1:0] = 2'(i % 4);
         if (i % 4 == 0) begin
            w[4:2] = 3'(i / 4);
            w[6:5] = 2'(i / 4);
            w[14:13] = 2'(i / 8 + i / 4);
            w[12:10] = 3'(7 - i / 4);
            w[17:15] = mux_tab[i / 4];
         end
         shrb_ctrl_model_inst.send_word(w);
         exp_w[i % 4] = w;
         if (w[1]) exp_pulses++;
         repeat (10) @(posedge clk_i);
         chk_all();
         // Lock pin follows the selected source
         for (int k = 0; k < 4 && i % 4 == 0; k++) begin
            #1 {lck, rdv, fbd, tst} = 4'($urandom);
            repeat (2) @(posedge clk_i);
            chk(26'(pin), 26'(f_pin(w[17:15])), "lock pin");
         end
      end
      stop_test();
   end
endmodule
